// *** irq_map.svh ***
// Header of constants for the upper vector and wakeup map
`ifndef IRQ_VECTOR_WAKEUP_MAP_UPPER_MAP_SVH
`define IRQ_VECTOR_WAKEUP_MAP_UPPER_MAP_SVH
`define VEC_BASE_ADDR 24'h008008
`define VEC_STEP 24'h000004
`define LINE_FIRST 5'h15
`define LINE_LAST 5'h1D
`define LINE_COUNT 9
// Wake masks over lines 21..29, bit 0 is line 21
`define HALT_WAKE_MASK 9'h120
// Advanced timer lines 23 and 24 stay asleep in interrupt wait
`define IRQ_WAIT_WAKE_MASK 9'h1F3
`define EVENT_WAIT_WAKE_MASK 9'h1FF
// Advanced timer lines 23 and 24 as a mask
`define ADV_TIMER_MASK 9'h00C
`define TWO_WIRE_BIT 8
`define SYNC_SERIAL_ONE_BIT 5
// First and last vector of the upper block, and word alignment
`define VEC_FIRST_ADDR 24'h00805C
`define VEC_LAST_ADDR 24'h00807C
`define VEC_ALIGN_MASK 24'h000003
`endif

// *** irq_pkg.sv ***
// Package of types for the upper vector and wakeup map
package irq_pkg;
    // Core power state, one-hot
    typedef enum logic [4:0] {
        PWR_RUN = 5'h01,
        PWR_HALT = 5'h02,
        PWR_WAIT_IRQ = 5'h04,
        PWR_WAIT_EVENT = 5'h08,
        PWR_LP_WAIT = 5'h10
    } power_state_t;
    // Controller sequencing state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SERVE = 3'h2,
        ST_RETURN = 3'h4
    } ctl_state_t;
endpackage

// *** irq_line_merge.sv ***
// Merge of peripheral causes onto shared request lines
`timescale 1ns/1ns
`default_nettype none
`include "irq_map.svh"
module irq_line_merge #(
    parameter int CAUSES = 2
) (
    // Cause pending and enable bits
    input wire logic [CAUSES-1:0] cause_pend,
    input wire logic [CAUSES-1:0] cause_en,
    // Merged line
    output logic line_out
);
    // Line stays high until the owning peripherals clear every enabled cause
    assign line_out = |(cause_pend & cause_en);
endmodule
`default_nettype wire

// *** irq_vector_wakeup_map_upper.sv ***
// Vector map, line merge and wakeup decision for lines 21 to 29
// Function
// - Lines 21..29 vectors from 0x805C step four
// - Halt wakes only 26,29; 23,24 not irq-wait
// - Wait-for-event in low-power run enters low-power wait
// - Top-level request ORs gp timer a, basic timer
// - Voltage detector ORed onto selected port E/F line
// - Two-wire wakes from halt only on address match
// - Event-mode service only if enabled, then return
// - Wakeup-event source resumes core without vectoring
// - Line 0 vector 0x8008, plus four per line
`timescale 1ns/1ns
`default_nettype none
`include "irq_map.svh"
module irq_vector_wakeup_map_upper #(
    parameter int LINES = `LINE_COUNT
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic SRST,
    // Core power state and instruction strobes
    input wire irq_pkg::power_state_t POWER_STATE,
    input wire logic LOW_POWER_RUN,
    input wire logic EVENT_WAIT_EXEC,
    input wire logic SERVICE_DONE,
    // Raw sources
    input wire logic GP_TIMER_A_OVF,
    input wire logic BASIC_TIMER_OVF,
    input wire logic VOLTAGE_DETECTOR_IRQ,
    input wire logic PORT_E_IRQ,
    input wire logic PORT_F_IRQ,
    input wire logic PORT_IRQ_SELECT,
    input wire logic TWO_WIRE_ONE_IRQ,
    input wire logic TWO_WIRE_ADDR_MATCH,
    input wire logic SYNC_SERIAL_TWO_IRQ,
    // Upper lines 21..29, per-line enable and event config
    input wire logic [LINES-1:0] LINE_REQ,
    input wire logic [LINES-1:0] LINE_EN,
    input wire logic [LINES-1:0] LINE_IS_EVENT,
    // Outputs to core
    output logic TOP_LEVEL_IRQ,
    output logic PORT_EF_LINE,
    output logic WAKE,
    output logic VECTOR_VALID,
    output logic [23:0] VECTOR_ADDR,
    output logic RESUME_NO_VECTOR,
    output logic ENTER_LP_WAIT,
    output logic RETURN_TO_EVENT_WAIT
);
    import irq_pkg::*;
    // ==========================================
    // Combinational merges
    logic [LINES-1:0] req; // Effective requests after merges
    logic line29_merged; // Shared two-wire / sync serial two line
    logic [LINES-1:0] halt_mask; // Halt wake mask with address gate
    logic [LINES-1:0] pend_en; // Enabled pending lines
    logic [LINES-1:0] pend_evt; // Event-configured pending lines
    logic [3:0] first_idx; // Lowest pending enabled line index

    // Line 29 merge: two-wire only counts as one cause of the shared line
    irq_line_merge #(.CAUSES(2)) u_merge29 (
        .cause_pend({SYNC_SERIAL_TWO_IRQ, TWO_WIRE_ONE_IRQ}),
        .cause_en(2'h3),
        .line_out(line29_merged)
    );

    // Request vector: line 29 ORed with its merged form
    always_comb begin
        req = LINE_REQ;
        req[`TWO_WIRE_BIT] = LINE_REQ[`TWO_WIRE_BIT] | line29_merged;
        halt_mask = `HALT_WAKE_MASK;
        // Only an address match, sync serial two or a raw line 29 request may wake line 29 from halt
        if (!TWO_WIRE_ADDR_MATCH && !SYNC_SERIAL_TWO_IRQ && !LINE_REQ[`TWO_WIRE_BIT]) begin
            halt_mask[`TWO_WIRE_BIT] = 1'b0;
        end
        pend_en = req & LINE_EN & ~LINE_IS_EVENT;
        pend_evt = req & LINE_IS_EVENT;
        first_idx = 4'h0;
        for (int i = LINES - 1; i >= 0; i--) begin
            if (pend_en[i]) begin
                first_idx = 4'(i);
            end
        end
    end

    // ==========================================
    // Registered state
    typedef struct packed {
        ctl_state_t st;
        logic top_irq;
        logic ef_line;
        logic wake;
        logic vvalid;
        logic [23:0] vaddr;
        logic resume;
        logic lp_wait;
        logic ret_evt_wait;
    } state_t;
    state_t s_reg, s_next;

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.top_irq = GP_TIMER_A_OVF | BASIC_TIMER_OVF;
        s_next.ef_line = (PORT_IRQ_SELECT ? PORT_F_IRQ : PORT_E_IRQ) | VOLTAGE_DETECTOR_IRQ;
        s_next.lp_wait = EVENT_WAIT_EXEC & LOW_POWER_RUN;
        s_next.resume = 1'b0;
        s_next.ret_evt_wait = 1'b0;
        s_next.vvalid = 1'b0;
        // Wake decision by power state
        case (POWER_STATE)
            PWR_HALT: s_next.wake = |(req & halt_mask);
            PWR_WAIT_IRQ: s_next.wake = |(req & `IRQ_WAIT_WAKE_MASK);
            PWR_WAIT_EVENT, PWR_LP_WAIT: begin
                // Event wait wakes only on lines enabled or set up as events
                s_next.wake = |(req & `EVENT_WAIT_WAKE_MASK & (LINE_EN | LINE_IS_EVENT));
            end
            default: s_next.wake = 1'b0;
        endcase
        case (s_reg.st)
            ST_IDLE: begin
                if ((POWER_STATE == PWR_WAIT_EVENT || POWER_STATE == PWR_LP_WAIT) && |pend_evt) begin
                    s_next.resume = 1'b1;
                end else if (|pend_en) begin
                    // Vector = base + 4 * (21 + index)
                    s_next.vvalid = 1'b1;
                    s_next.vaddr = `VEC_BASE_ADDR + `VEC_STEP * (24'(`LINE_FIRST) + 24'(first_idx));
                    s_next.st = ST_SERVE;
                end
            end
            ST_SERVE: begin
                if (SERVICE_DONE) begin
                    s_next.st = ST_RETURN;
                end
            end
            ST_RETURN: begin
                // Back to event wait only if the core is in event wait during the return cycle
                s_next.ret_evt_wait = (POWER_STATE == PWR_WAIT_EVENT || POWER_STATE == PWR_LP_WAIT);
                s_next.st = ST_IDLE;
            end
            default: s_next.st = ST_IDLE;
        endcase
        if (SRST) begin
            s_next = '0;
            s_next.st = ST_IDLE;
        end
    end

    // State register
    always_ff @(posedge SYS_CLK) begin
        s_reg <= s_next;
    end

    assign TOP_LEVEL_IRQ = s_reg.top_irq;
    assign PORT_EF_LINE = s_reg.ef_line;
    assign WAKE = s_reg.wake;
    assign VECTOR_VALID = s_reg.vvalid;
    assign VECTOR_ADDR = s_reg.vaddr;
    assign RESUME_NO_VECTOR = s_reg.resume;
    assign ENTER_LP_WAIT = s_reg.lp_wait;
    assign RETURN_TO_EVENT_WAIT = s_reg.ret_evt_wait;

    // ==========================================
    // Assertions
    property p_vec_range;
        @(posedge SYS_CLK) disable iff (SRST)
        VECTOR_VALID |-> (VECTOR_ADDR >= `VEC_FIRST_ADDR && VECTOR_ADDR <= `VEC_LAST_ADDR
                          && (VECTOR_ADDR & `VEC_ALIGN_MASK) == 24'h000000);
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector out of range");

    property p_vec_idx;
        @(posedge SYS_CLK) disable iff (SRST)
        (s_reg.st == ST_IDLE && !(|pend_evt) && pend_en[0]) |=> (VECTOR_ADDR == `VEC_FIRST_ADDR);
    endproperty
    a_vec_idx: assert property (p_vec_idx) else $error("line 21 vector wrong");

    // Written from the two halt-capable lines, not from the wake mask itself
    property p_halt_no_timer;
        @(posedge SYS_CLK) disable iff (SRST)
        (POWER_STATE == PWR_HALT && !req[`SYNC_SERIAL_ONE_BIT] && !req[`TWO_WIRE_BIT]) |=> !WAKE;
    endproperty
    a_halt_no_timer: assert property (p_halt_no_timer) else $error("bad halt wake");

    property p_irq_wait_adv;
        @(posedge SYS_CLK) disable iff (SRST)
        (POWER_STATE == PWR_WAIT_IRQ && (req & ~`ADV_TIMER_MASK) == 9'h000) |=> !WAKE;
    endproperty
    a_irq_wait_adv: assert property (p_irq_wait_adv) else $error("advanced timer woke interrupt wait");

    property p_lp_wait;
        @(posedge SYS_CLK) disable iff (SRST)
        (EVENT_WAIT_EXEC && LOW_POWER_RUN) |=> ENTER_LP_WAIT;
    endproperty
    a_lp_wait: assert property (p_lp_wait) else $error("low-power wait missed");

    property p_top;
        @(posedge SYS_CLK) disable iff (SRST)
        (GP_TIMER_A_OVF || BASIC_TIMER_OVF) |=> TOP_LEVEL_IRQ;
    endproperty
    a_top: assert property (p_top) else $error("top-level irq missed");

    property p_ef;
        @(posedge SYS_CLK) disable iff (SRST)
        VOLTAGE_DETECTOR_IRQ |=> PORT_EF_LINE;
    endproperty
    a_ef: assert property (p_ef) else $error("detector not merged");

    property p_two_wire_halt;
        @(posedge SYS_CLK) disable iff (SRST)
        (POWER_STATE == PWR_HALT && !TWO_WIRE_ADDR_MATCH && !SYNC_SERIAL_TWO_IRQ
         && !LINE_REQ[`TWO_WIRE_BIT] && !LINE_REQ[`SYNC_SERIAL_ONE_BIT]) |=> !WAKE;
    endproperty
    a_two_wire_halt: assert property (p_two_wire_halt) else $error("two-wire woke without match");

    // A vector needs some line that is enabled as an interrupt
    property p_vec_en;
        @(posedge SYS_CLK) disable iff (SRST)
        VECTOR_VALID |-> $past(|(LINE_EN & ~LINE_IS_EVENT));
    endproperty
    a_vec_en: assert property (p_vec_en) else $error("vector without enabled line");

    // Service ends: done seen while serving, then one return cycle
    sequence s_served;
        (s_reg.st == ST_SERVE && SERVICE_DONE) ##1 (s_reg.st == ST_RETURN);
    endsequence
    property p_ret_wait;
        @(posedge SYS_CLK) disable iff (SRST)
        s_served |=> (RETURN_TO_EVENT_WAIT == $past(POWER_STATE == PWR_WAIT_EVENT || POWER_STATE == PWR_LP_WAIT));
    endproperty
    a_ret_wait: assert property (p_ret_wait) else $error("return to event wait wrong");

    property p_resume;
        @(posedge SYS_CLK) disable iff (SRST)
        (s_reg.st == ST_IDLE && (POWER_STATE == PWR_WAIT_EVENT || POWER_STATE == PWR_LP_WAIT)
         && |(LINE_REQ & LINE_IS_EVENT)) |=> (RESUME_NO_VECTOR && !VECTOR_VALID);
    endproperty
    a_resume: assert property (p_resume) else $error("event source did not resume");
endmodule
`default_nettype wire

// *** irq_core_model.sv ***
// Behavioural core model that acknowledges served vectors
`timescale 1ns/1ns
`default_nettype none
module irq_core_model (
    // Clock
    input wire logic clk,
    // Vector strobe and acknowledge delay
    input wire logic vec_valid,
    input wire logic [3:0] dly,
    // Service completion pulse
    output logic done
);
    // ==========
    // Service runs for a chosen delay, so prompt and slow handlers are both seen
    // One process owns the done pulse, from its idle level onwards
    initial begin
        done = 1'b0;
        forever begin
            @(posedge clk);
            if (vec_valid === 1'b1) begin
                repeat (dly) @(posedge clk);
                done <= 1'b1;
                @(posedge clk);
                done <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** irq_vector_wakeup_map_upper_tb.sv ***
// Self-checking bench for the upper vector and wakeup map
`timescale 1ns/1ns
`default_nettype none
module irq_vector_wakeup_map_upper_tb;
    import irq_pkg::*;
    // ==========
    // Stimulus and observation
    logic clk = 1'b0, srst = 1'b1, lpr = 1'b0, wfx = 1'b0, gpa = 1'b0, bto = 1'b0, vdi = 1'b0;
    logic pe = 1'b0, pf = 1'b0, psel = 1'b0, tw = 1'b0, twm = 1'b0, ss2 = 1'b0;
    logic [8:0] req = 9'h000, en = 9'h000, ev = 9'h000;
    power_state_t pst = PWR_RUN;
    logic top_q, pef, wake, vv, rnv, elp, rtw, done;
    logic [23:0] va;
    logic [3:0] dly = 4'h0;
    logic [31:0] rng = 32'h00008B83;
    logic [23:0] expq[$];
    int mismatches = 0, checks = 0, rets = 0, res = 0;
    always #5 clk = ~clk;
    irq_vector_wakeup_map_upper dut_u (.SYS_CLK(clk), .SRST(srst), .POWER_STATE(pst), .LOW_POWER_RUN(lpr),
        .EVENT_WAIT_EXEC(wfx), .SERVICE_DONE(done), .GP_TIMER_A_OVF(gpa), .BASIC_TIMER_OVF(bto),
        .VOLTAGE_DETECTOR_IRQ(vdi), .PORT_E_IRQ(pe), .PORT_F_IRQ(pf), .PORT_IRQ_SELECT(psel),
        .TWO_WIRE_ONE_IRQ(tw), .TWO_WIRE_ADDR_MATCH(twm), .SYNC_SERIAL_TWO_IRQ(ss2), .LINE_REQ(req),
        .LINE_EN(en), .LINE_IS_EVENT(ev), .TOP_LEVEL_IRQ(top_q), .PORT_EF_LINE(pef), .WAKE(wake),
        .VECTOR_VALID(vv), .VECTOR_ADDR(va), .RESUME_NO_VECTOR(rnv), .ENTER_LP_WAIT(elp),
        .RETURN_TO_EVENT_WAIT(rtw));
    irq_core_model core_u (.clk(clk), .vec_valid(vv), .dly(dly), .done(done));
    // ==========
    // Helpers
    // Xorshift step for the random request patterns
    function automatic logic [31:0] xorshift(logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        y = y ^ (y << 5);
        return y;
    endfunction
    task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Registered levels follow one cycle late, so two edges are always enough
    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic vec(logic [8:0] r, logic [23:0] e);
        int n;
        n = 0;
        expq.push_back(e);
        @(posedge clk);
        req <= r;
        while (vv !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (vv !== 1'b1) check("vector_timeout", 24'h1, 24'h0);
        req <= 9'h000;
        repeat (dly + 5) @(posedge clk);
    endtask
    // ==========
    // Monitor takes the oldest note on every vector and counts pulses
    always @(posedge clk) begin
        if (vv === 1'b1) begin
            if (expq.size() == 0) check("vector_extra", 24'h1, 24'h0);
            else check("vector_addr", va, expq.pop_front());
        end
        if (rtw === 1'b1) rets++;
        if (rnv === 1'b1) res++;
    end
    initial begin
        #200000;
        mismatches++;
        final_report();
    end
    // ==========
    // Main sequence
    initial begin
        power_state_t ps[3] = '{PWR_HALT, PWR_WAIT_IRQ, PWR_WAIT_EVENT};
        logic [8:0] wm[3] = '{9'h120, 9'h1F3, 9'h1FF};
        int r0, idx;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        #1 check("reset_outputs", 24'({top_q, pef, wake, vv, rnv, elp, rtw}), 24'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {bto, gpa} <= i[1:0];
            settle();
            check("top_level_irq", 24'(top_q), 24'(i[0] | i[1]));
        end
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            {vdi, psel, pf, pe} <= i[3:0];
            settle();
            check("port_ef_line", 24'(pef), 24'(i[3] | (i[2] ? i[1] : i[0])));
        end
        $display("test merge done");
        @(posedge clk);
        ev <= 9'h1FF;
        for (int s = 0; s < 3; s++) begin
            for (int l = 0; l < 9; l++) begin
                @(posedge clk);
                pst <= ps[s];
                req <= 9'h001 << l;
                settle();
                check("wake_line", 24'(wake), 24'(wm[s][l]));
                @(posedge clk);
                req <= 9'h000;
                settle();
            end
        end
        check("resume_count", 24'(res >= 9), 24'h1);
        @(posedge clk);
        pst <= PWR_HALT;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {ss2, twm, tw} <= i[2:0];
            settle();
            check("two_wire_wake", 24'(wake), 24'((i[0] & i[1]) | i[2]));
        end
        @(posedge clk);
        {ss2, twm, tw} <= 3'h0;
        pst <= PWR_RUN;
        $display("test wake done");
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            lpr <= i[0];
            wfx <= 1'b1;
            @(posedge clk);
            wfx <= 1'b0;
            #1 check("enter_lp_wait", 24'(elp), 24'(i));
        end
        @(posedge clk);
        lpr <= 1'b0;
        pst <= PWR_WAIT_EVENT;
        ev <= 9'h000;
        req <= 9'h001;
        settle();
        check("event_wait_disabled_wake", 24'(wake), 24'h0);
        @(posedge clk);
        req <= 9'h000;
        en <= 9'h1FF;
        settle();
        r0 = rets;
        for (int k = 0; k < 6; k++) begin
            rng = xorshift(rng);
            dly = rng[12:9];
            idx = 0;
            for (int b = 8; b >= 0; b--) if (rng[b] || (b == 0 && rng[8:0] == 9'h000)) idx = b;
            vec(rng[8:0] | 9'(rng[8:0] == 9'h000), 24'h008008 + 24'(4 * (21 + idx)));
        end
        check("return_count", 24'(rets - r0), 24'h6);
        check("queue_empty", 24'(expq.size()), 24'h0);
        $display("test vectors done");
        final_report();
    end
endmodule
`default_nettype wire
